/* File: include/disk_fmt_pkg.sv */
// Purpose: Shared constants and types for the sector formatter.
// Assumes: 16-bit parcels, 250 MHz clock.
// Notes:   ID field layout and gap length are fixed here.
package disk_fmt_pkg;

  // Widths
  localparam int PARCEL_W = 16;
  localparam int CNT_W    = 12;
  localparam int IDX_W    = 11;
  localparam int DEF_W    = 10;

  // Sector geometry
  localparam int SECTOR_BYTES = 4096;
  localparam int PARCEL_BYTES = 2;
  localparam int PAD_BYTES    = 18;
  localparam logic [CNT_W-1:0] DATA_PARCELS =
    CNT_W'(SECTOR_BYTES / PARCEL_BYTES);
  localparam logic [3:0] PAD_PARCELS = 4'(PAD_BYTES / PARCEL_BYTES);
  localparam logic [1:0] WORD_TO_PARCEL = 2'h0; // Four parcels per word

  // ID field limits; the defect value marks an unflawed data area
  localparam logic [DEF_W-1:0] DEFECT_NONE = 10'h204;
  localparam logic [11:0]      CYL_MAX     = 12'hA32;
  localparam logic [4:0]       HEAD_MAX    = 5'h12;
  localparam logic [3:0]       SECT_MAX    = 4'hA;

  // Gap between ID and data command
  localparam int CLK_NS     = 4;
  localparam int GAP_NS     = 40;
  localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] GAP_LOAD = 4'(GAP_CYCLES);

  typedef enum logic [2:0] {
    FLD_TIMING  = 3'h0,
    FLD_ID      = 3'h1,
    FLD_DATA    = 3'h2,
    FLD_ECC     = 3'h3,
    FLD_SWALLOW = 3'h4
  } field_e;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_GAP   = 8'h02,
    ST_WDATA = 8'h04,
    ST_WPAD  = 8'h08,
    ST_WECC  = 8'h10,
    ST_RDATA = 8'h20,
    ST_RSKIP = 8'h40,
    ST_RECC  = 8'h80
  } state_e;

  // Eight-byte identifier, msb first
  typedef struct packed {
    logic             spare;
    logic [11:0]      cylinder;
    logic             write_lock_bit;
    logic             read_lock_bit;
    logic [4:0]       head;
    logic [3:0]       sector;
    logic             known_hideable_flag;
    logic             unmaskable_flaw_flag;
    logic             id_flaw_flag;
    logic [DEF_W-1:0] defect;
    logic [26:0]      filler;
  } sector_id_s;

  typedef struct packed {
    logic wr_start;
    logic rd_start;
    logic wr_lock_override;
    logic rd_lock_override;
  } ctl_s;

  typedef struct packed {
    logic                refused;
    logic                id_error;
    logic                addr_bad;
    logic                data_error;
    logic                done;
    logic [PARCEL_W-1:0] corr_mask;
    logic [IDX_W-1:0]    corr_index;
  } stat_s;

  typedef struct packed {
    logic [PARCEL_W-1:0] p;
    logic [PARCEL_W-1:0] q;
  } ecc_s;

  typedef struct packed {
    state_e              st;
    field_e              field;
    sector_id_s          id;
    logic [CNT_W-1:0]    pcount;
    logic [DEF_W-1:0]    defect;
    logic [3:0]          dcount;
    logic [3:0]          gap;
    logic                pad_on;
    logic                padded;
    logic                wr_mode;
    logic                ecc_half;
    logic [PARCEL_W-1:0] last;
    logic [PARCEL_W-1:0] stored_p;
    logic                drv_valid;
    logic [PARCEL_W-1:0] drv_data;
    logic                rd_valid;
    logic [PARCEL_W-1:0] rd_data;
    stat_s               stat;
  } fmt_state_s;

  localparam fmt_state_s FMT_RESET =
    '{st: ST_IDLE, field: FLD_TIMING, default: '0};

endpackage

/* File: src/parcel_ecc.sv */
// Purpose: Running check code over a stream of parcels.
// Assumes: At most 2048 parcels per field.
// Notes:   Column parity plus index code locates one flipped bit.
`timescale 1ns/100ps
`default_nettype none
module parcel_ecc (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             ce,
  input  wire logic                             clear,
  input  wire logic                             en,
  input  wire logic [disk_fmt_pkg::PARCEL_W-1:0] data,
  input  wire logic [disk_fmt_pkg::IDX_W-1:0]    index,
  output logic      [disk_fmt_pkg::PARCEL_W-1:0] p,
  output logic      [disk_fmt_pkg::PARCEL_W-1:0] q
);

  disk_fmt_pkg::ecc_s s;
  disk_fmt_pkg::ecc_s next_s;

  // Odd-parity parcels fold their index into q
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s = '0;
    end else if (en) begin
      next_s.p = s.p ^ data;
      next_s.q = s.q ^ ({5'h00, index} & {disk_fmt_pkg::PARCEL_W{^data}});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign p = s.p;
  assign q = s.q;

endmodule
`default_nettype wire

/* File: src/disk_sector_defect_pad_writer.sv */
// Purpose: Sector formatter with defect pad insert and removal.
// Assumes: Drive and buffer sides run on clk; one operation at a time.
// Notes:   ID must be loaded before a start; status pulses are one cycle.
`timescale 1ns/100ps
`default_nettype none
module disk_sector_defect_pad_writer (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              ce,
  input  wire disk_fmt_pkg::ctl_s                ctl,
  input  wire logic                              id_valid,
  input  wire logic [63:0]                       id_word,
  input  wire logic [31:0]                       id_code,
  input  wire logic                              up_valid,
  input  wire logic [disk_fmt_pkg::PARCEL_W-1:0] up_data,
  output logic                                   up_ready,
  output logic                                   drv_valid,
  output logic      [disk_fmt_pkg::PARCEL_W-1:0] drv_data,
  input  wire logic                              drv_ready,
  input  wire logic                              din_valid,
  input  wire logic [disk_fmt_pkg::PARCEL_W-1:0] din_data,
  output logic                                   din_ready,
  output logic                                   rd_valid,
  output logic      [disk_fmt_pkg::PARCEL_W-1:0] rd_data,
  output disk_fmt_pkg::field_e                   field,
  output logic                                   busy,
  output disk_fmt_pkg::stat_s                    stat
);

  disk_fmt_pkg::fmt_state_s s;
  disk_fmt_pkg::fmt_state_s next_s;
  disk_fmt_pkg::sector_id_s id_in;
  logic                              slot;
  logic                              pad_due;
  logic [disk_fmt_pkg::CNT_W-1:0]    pad_start;
  logic                              ecc_clr;
  logic                              ecc_en;
  logic [disk_fmt_pkg::PARCEL_W-1:0] ecc_data;
  logic [disk_fmt_pkg::PARCEL_W-1:0] ecc_p;
  logic [disk_fmt_pkg::PARCEL_W-1:0] ecc_q;
  logic [disk_fmt_pkg::PARCEL_W-1:0] syn_p;
  logic [disk_fmt_pkg::PARCEL_W-1:0] syn_q;

  // Check code of the four identifier parcels, p in the upper half
  function automatic logic [31:0] id_code_of(input logic [63:0] w);
    logic [15:0] p;
    logic [15:0] q;
    p = '0;
    q = '0;
    for (int i = 0; i < 4; i++) begin
      p = p ^ w[16*i +: 16];
      q = q ^ (16'(i) & {16{^w[16*i +: 16]}});
    end
    return {p, q};
  endfunction

  // Address out of the legal ranges
  function automatic logic addr_bad(input disk_fmt_pkg::sector_id_s id);
    return (id.cylinder > disk_fmt_pkg::CYL_MAX) ||
           (id.head > disk_fmt_pkg::HEAD_MAX) ||
           (id.sector > disk_fmt_pkg::SECT_MAX);
  endfunction

  // One code engine serves both directions; only one runs at a time
  parcel_ecc u_ecc (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (ecc_clr),
    .en    (ecc_en),
    .data  (ecc_data),
    .index (s.pcount[disk_fmt_pkg::IDX_W-1:0]),
    .p     (ecc_p),
    .q     (ecc_q)
  );

  assign id_in = disk_fmt_pkg::sector_id_s'(id_word);
  // Word number to parcel number
  assign pad_start = {s.defect, disk_fmt_pkg::WORD_TO_PARCEL};
  assign pad_due = s.pad_on && !s.padded &&
                   (s.pcount == pad_start);
  assign slot = !s.drv_valid || drv_ready;
  assign syn_p = ecc_p ^ s.stored_p;
  assign syn_q = ecc_q ^ din_data;

  // Next state of the whole formatter
  always_comb begin
    next_s = s;
    next_s.stat.refused = 1'b0;
    next_s.stat.id_error = 1'b0;
    next_s.stat.data_error = 1'b0;
    next_s.stat.done = 1'b0;
    next_s.rd_valid = 1'b0;
    up_ready = 1'b0;
    din_ready = 1'b0;
    ecc_clr = 1'b0;
    ecc_en = 1'b0;
    ecc_data = s.wr_mode ? up_data : din_data;
    if (s.drv_valid && drv_ready) begin
      next_s.drv_valid = 1'b0;
    end
    // Identifier capture and check, only while idle
    if (id_valid && s.st == disk_fmt_pkg::ST_IDLE) begin
      next_s.id = id_in;
      next_s.stat.id_error = id_code_of(id_word) != id_code;
      next_s.stat.addr_bad = addr_bad(id_in);
    end
    case (s.st)
      disk_fmt_pkg::ST_IDLE: begin
        if (ctl.wr_start || ctl.rd_start) begin
          // Locked sectors without their override, and unusable sectors, are refused outright
          if ((ctl.wr_start && s.id.write_lock_bit &&
               !ctl.wr_lock_override) ||
              (ctl.rd_start && s.id.read_lock_bit &&
               !ctl.rd_lock_override) ||
              s.id.unmaskable_flaw_flag || s.id.id_flaw_flag) begin
            next_s.stat.refused = 1'b1;
          end else begin
            next_s.wr_mode = ctl.wr_start;
            next_s.defect = s.id.defect;
            next_s.pcount = '0;
            next_s.pad_on = s.id.known_hideable_flag &&
              (s.id.defect != disk_fmt_pkg::DEFECT_NONE);
            next_s.padded = 1'b0;
            next_s.last = '0;
            next_s.ecc_half = 1'b0;
            next_s.gap = disk_fmt_pkg::GAP_LOAD;
            next_s.st = disk_fmt_pkg::ST_GAP;
            ecc_clr = 1'b1;
          end
        end
      end
      disk_fmt_pkg::ST_GAP: begin
        // Drive needs time to take the data command
        if (s.gap == 4'h1) begin
          next_s.st = s.wr_mode ? disk_fmt_pkg::ST_WDATA
                                : disk_fmt_pkg::ST_RDATA;
        end else begin
          next_s.gap = s.gap - 4'h1;
        end
      end
      disk_fmt_pkg::ST_WDATA: begin
        if (pad_due) begin
          next_s.st = disk_fmt_pkg::ST_WPAD;
          next_s.dcount = disk_fmt_pkg::PAD_PARCELS;
        end else if (s.pcount == disk_fmt_pkg::DATA_PARCELS) begin
          next_s.st = disk_fmt_pkg::ST_WECC;
        end else if (slot) begin
          up_ready = ce;
          if (up_valid) begin
            next_s.drv_valid = 1'b1;
            next_s.drv_data = up_data;
            next_s.last = up_data;
            next_s.pcount = s.pcount + 12'h001;
            ecc_en = 1'b1;
          end
        end
      end
      disk_fmt_pkg::ST_WPAD: begin
        // Upstream stays stalled; last parcel repeats into the swallow
        if (s.dcount == 4'h0) begin
          next_s.padded = 1'b1;
          next_s.st = disk_fmt_pkg::ST_WDATA;
        end else if (slot) begin
          next_s.drv_valid = 1'b1;
          next_s.drv_data = s.last;
          next_s.dcount = s.dcount - 4'h1;
        end
      end
      disk_fmt_pkg::ST_WECC: begin
        // Code goes out as two parcels, p then q
        if (slot) begin
          next_s.drv_valid = 1'b1;
          next_s.drv_data = s.ecc_half ? ecc_q : ecc_p;
          next_s.ecc_half = 1'b1;
          if (s.ecc_half) begin
            next_s.stat.done = 1'b1;
            next_s.st = disk_fmt_pkg::ST_IDLE;
          end
        end
      end
      disk_fmt_pkg::ST_RDATA: begin
        if (pad_due) begin
          next_s.st = disk_fmt_pkg::ST_RSKIP;
          next_s.dcount = disk_fmt_pkg::PAD_PARCELS;
        end else if (s.pcount == disk_fmt_pkg::DATA_PARCELS) begin
          next_s.st = disk_fmt_pkg::ST_RECC;
        end else begin
          din_ready = ce;
          if (din_valid) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data = din_data;
            next_s.pcount = s.pcount + 12'h001;
            ecc_en = 1'b1;
          end
        end
      end
      disk_fmt_pkg::ST_RSKIP: begin
        // Pad parcels are taken from the drive and dropped
        if (s.dcount == 4'h0) begin
          next_s.padded = 1'b1;
          next_s.st = disk_fmt_pkg::ST_RDATA;
        end else begin
          din_ready = ce;
          if (din_valid) begin
            next_s.dcount = s.dcount - 4'h1;
          end
        end
      end
      disk_fmt_pkg::ST_RECC: begin
        din_ready = ce;
        if (din_valid && !s.ecc_half) begin
          next_s.stored_p = din_data;
          next_s.ecc_half = 1'b1;
        end else if (din_valid) begin
          // Syndromes give bit mask and parcel index of one bad bit
          next_s.stat.data_error = |{syn_p, syn_q};
          next_s.stat.corr_mask = syn_p;
          next_s.stat.corr_index = syn_q[disk_fmt_pkg::IDX_W-1:0];
          next_s.stat.done = 1'b1;
          next_s.st = disk_fmt_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.st = disk_fmt_pkg::ST_IDLE;
      end
    endcase
    // Field currently on the drive side
    case (next_s.st)
      disk_fmt_pkg::ST_WDATA,
      disk_fmt_pkg::ST_RDATA: next_s.field = disk_fmt_pkg::FLD_DATA;
      disk_fmt_pkg::ST_WPAD,
      disk_fmt_pkg::ST_RSKIP: next_s.field = disk_fmt_pkg::FLD_SWALLOW;
      disk_fmt_pkg::ST_WECC,
      disk_fmt_pkg::ST_RECC: next_s.field = disk_fmt_pkg::FLD_ECC;
      disk_fmt_pkg::ST_IDLE: begin
        next_s.field = id_valid ? disk_fmt_pkg::FLD_ID
                                : disk_fmt_pkg::FLD_TIMING;
      end
      default: next_s.field = disk_fmt_pkg::FLD_TIMING;
    endcase
  end

  // Single state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= disk_fmt_pkg::FMT_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Valids gated by ce so a frozen cycle never counts as a transfer
  assign drv_valid = s.drv_valid && ce;
  assign drv_data  = s.drv_data;
  assign rd_valid  = s.rd_valid && ce;
  assign rd_data   = s.rd_data;
  assign field     = s.field;
  assign busy      = s.st != disk_fmt_pkg::ST_IDLE;
  assign stat      = s.stat;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_WR_LOCK:
  assert property (ce && s.st == disk_fmt_pkg::ST_IDLE && ctl.wr_start &&
                   s.id.write_lock_bit && !ctl.wr_lock_override
                   |=> s.stat.refused && s.st == disk_fmt_pkg::ST_IDLE)
    else $error("locked sector write not refused");

  AST_RD_LOCK:
  assert property (ce && s.st == disk_fmt_pkg::ST_IDLE && ctl.rd_start &&
                   !ctl.wr_start && s.id.read_lock_bit &&
                   !ctl.rd_lock_override
                   |=> s.stat.refused && !busy)
    else $error("locked sector read not refused");

  AST_LOAD:
  assert property (ce && s.st == disk_fmt_pkg::ST_IDLE &&
                   next_s.st == disk_fmt_pkg::ST_GAP
                   |=> s.pcount == 12'h000 && s.defect == $past(s.id.defect))
    else $error("defect value or count not loaded");

  AST_COUNT:
  assert property (ce && up_valid && up_ready
                   |=> s.pcount == $past(s.pcount) + 12'h001 && s.drv_valid)
    else $error("parcel count did not advance");

  AST_PAD_ENTRY:
  assert property (ce && s.st == disk_fmt_pkg::ST_WDATA && pad_due
                   |=> s.st == disk_fmt_pkg::ST_WPAD &&
                       s.dcount == disk_fmt_pkg::PAD_PARCELS &&
                       $stable(s.pcount))
    else $error("pad not started at count match");

  AST_STALL:
  assert property (s.st == disk_fmt_pkg::ST_WPAD |-> !up_ready)
    else $error("upstream not stalled during pad");

  AST_PAD_REPEAT:
  assert property (s.st == disk_fmt_pkg::ST_WPAD && s.drv_valid
                   |-> s.drv_data == s.last)
    else $error("pad parcel differs from last parcel");

  AST_PAD_END:
  assert property (ce && s.st == disk_fmt_pkg::ST_WPAD && s.dcount == 4'h0
                   |=> s.st == disk_fmt_pkg::ST_WDATA && s.padded)
    else $error("pad did not end cleanly");

  AST_SKIP:
  assert property (ce && s.st == disk_fmt_pkg::ST_RSKIP |=> !s.rd_valid)
    else $error("pad parcel passed to reader");

  AST_GAP:
  assert property (ce && s.st == disk_fmt_pkg::ST_IDLE &&
                   next_s.st == disk_fmt_pkg::ST_GAP
                   |=> s.st == disk_fmt_pkg::ST_GAP [*2])
    else $error("gap too short");

  COV_WR_PAD: cover property (s.st == disk_fmt_pkg::ST_WPAD &&
                              s.dcount == 4'h0);
  COV_RD_SKIP: cover property (s.st == disk_fmt_pkg::ST_RSKIP &&
                               s.dcount == 4'h0);
  COV_REFUSE: cover property (s.stat.refused);
  COV_DATA_ERR: cover property (s.stat.data_error);

endmodule
`default_nettype wire

/* File: verif/drive_model.sv */
// Purpose: Behavioural disk drive on the formatter's parcel ports.
// Assumes: Same clock as the formatter; outputs change 1 ns after edges.
// Notes:   Stores written parcels and replays them on reads.
`timescale 1ns/100ps
`default_nettype none
module drive_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        drv_valid,
  input  wire logic [15:0] drv_data,
  output logic             drv_ready,
  output logic             din_valid,
  output logic [15:0]      din_data,
  input  wire logic        din_ready,
  input  wire logic        play,
  input  wire logic [11:0] flip_idx,
  input  wire logic [15:0] flip_mask
);
  logic [15:0] wq[$];
  int          ridx;
  int          tick;
  logic        took;

  initial begin
    drv_ready = 1'b0;
    din_valid = 1'b0;
    din_data  = 16'h0000;
    ridx      = 0;
    tick      = 0;
  end

  // Capture and replay; ready stalls now and then, like a slow drive
  always @(posedge clk) begin
    took = din_valid && din_ready;
    if (drv_valid && drv_ready)
      wq.push_back(drv_data);
    if (took)
      ridx++;
    if (!play)
      ridx = 0;
    tick++;
    #1;
    drv_ready = rst_n && (tick % 5 != 0);
    // Offered parcel holds until taken; idle bus shows inverted data
    if (!din_valid || took || !play) begin
      din_valid = play && (ridx < wq.size()) && (tick % 7 != 0);
      din_data  = din_valid ?
        wq[ridx] ^ ((ridx == flip_idx) ? flip_mask : 16'h0000) : ~din_data;
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_disk_sector_defect_pad_writer.sv */
// Purpose: Self-checking bench for the sector formatter.
// Assumes: Drive model on the drive side; bench acts as upstream buffer.
// Notes:   Pad at word 10, i.e. after logical parcel 39.
`timescale 1ns/100ps
`default_nettype none
module test_disk_sector_defect_pad_writer;
  logic                clk;
  logic                rst_n;
  logic                ce;
  disk_fmt_pkg::ctl_s  ctl;
  logic                id_valid;
  logic [63:0]         id_word;
  logic [31:0]         id_code;
  logic                up_valid;
  logic [15:0]         up_data;
  logic                up_ready;
  logic                drv_valid;
  logic [15:0]         drv_data;
  logic                drv_ready;
  logic                din_valid;
  logic [15:0]         din_data;
  logic                din_ready;
  logic                rd_valid;
  logic [15:0]         rd_data;
  disk_fmt_pkg::field_e field;
  logic                busy;
  disk_fmt_pkg::stat_s stat;
  logic                play;
  logic [11:0]         flip_idx;
  logic [15:0]         flip_mask;
  int                  err_total;
  int                  num_checks;
  logic                s_done;
  logic                s_ref;
  logic                s_ide;
  logic                s_de;
  logic                rchk;
  int                  rcnt;
  int                  sw_cnt;

  disk_sector_defect_pad_writer dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .ctl(ctl), .id_valid(id_valid), .id_word(id_word), .id_code(id_code),
    .up_valid(up_valid), .up_data(up_data), .up_ready(up_ready),
    .drv_valid(drv_valid), .drv_data(drv_data), .drv_ready(drv_ready),
    .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .field(field), .busy(busy),
    .stat(stat));

  drive_model drive (.clk(clk), .rst_n(rst_n), .drv_valid(drv_valid),
    .drv_data(drv_data), .drv_ready(drv_ready), .din_valid(din_valid),
    .din_data(din_data), .din_ready(din_ready), .play(play),
    .flip_idx(flip_idx), .flip_mask(flip_mask));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] pat(input int i);
    return 16'(i * 263) ^ 16'hA55A;
  endfunction

  function automatic disk_fmt_pkg::sector_id_s mk_id(input logic [11:0] cyl,
      input logic [3:0] f, input logic [9:0] d);
    mk_id = '0;
    mk_id.cylinder = cyl;
    {mk_id.write_lock_bit, mk_id.read_lock_bit} = f[3:2];
    {mk_id.known_hideable_flag, mk_id.unmaskable_flaw_flag} = f[1:0];
    mk_id.head = 5'h03;
    mk_id.sector = 4'h2;
    mk_id.defect = d;
  endfunction

  // Check code of the identifier: parcel xor, then odd-parity index xor;
  // the index counts from the low parcel of the word, as the formatter does
  function automatic logic [31:0] mk_code(input logic [63:0] w);
    logic [15:0] pp;
    logic [15:0] p;
    logic [15:0] q;
    p = 16'h0000;
    q = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      pp = w[16*i +: 16];
      p ^= pp;
      if (^pp)
        q ^= 16'(i);
    end
    return {p, q};
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Status pulses last one cycle, so they are latched here
  always @(posedge clk) begin
    if (stat.done === 1'b1) s_done = 1'b1;
    if (stat.refused === 1'b1) s_ref = 1'b1;
    if (stat.id_error === 1'b1) s_ide = 1'b1;
    if (stat.data_error === 1'b1) s_de = 1'b1;
    if (field === disk_fmt_pkg::FLD_SWALLOW) sw_cnt++;
    if (rd_valid === 1'b1) begin
      if (rchk)
        chk_val("rd_data", 32'(pat(rcnt)), 32'(rd_data));
      rcnt++;
    end
  end

  task automatic clr();
    {s_done, s_ref, s_ide, s_de} = 4'h0;
    rcnt = 0;
    sw_cnt = 0;
  endtask

  task automatic load_id(input disk_fmt_pkg::sector_id_s id,
      input logic bad);
    clr();
    id_word = id;
    id_code = mk_code(id) ^ {31'h0, bad};
    id_valid = 1'b1;
    @(posedge clk);
    #1 id_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic start(input logic rd);
    if (rd) ctl.rd_start = 1'b1;
    else ctl.wr_start = 1'b1;
    @(posedge clk);
    #1 ctl.rd_start = 1'b0;
    ctl.wr_start = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Done comes with the last code parcel still offered; wait for it too
  task automatic wait_done();
    for (int n = 0; n < 20000 && (!s_done || drv_valid !== 1'b0); n++)
      @(posedge clk);
    #1;
    if (!s_done || drv_valid !== 1'b0) begin
      err_total++;
      $display("unexpected done expected 1 seen %b", s_done);
      finish_test();
    end
  endtask

  task automatic write_sector(input logic pad);
    int k;
    int gapc;
    int off;
    logic [15:0] p;
    logic [15:0] q;
    drive.wq.delete();
    start(1'b0);
    k = 0;
    gapc = 0;
    up_valid = 1'b1;
    up_data = pat(0);
    // Buffer side: new parcel only after a taken one, none while stalled
    for (int n = 0; n < 30000 && k < 2048; n++) begin
      @(posedge clk);
      if (up_ready === 1'b1) k++;
      else if (k == 0) gapc++;
      #1 up_data = pat(k);
    end
    up_valid = 1'b0;
    if (k < 2048) begin
      err_total++;
      $display("unexpected parcels expected 2048 seen %0d", k);
      finish_test();
    end
    wait_done();
    chk_bit("gap", 1'b1, gapc >= disk_fmt_pkg::GAP_CYCLES - 1);
    chk_bit("swallow", pad, sw_cnt >= 9);
    off = pad ? 9 : 0;
    chk_val("drive_len", 32'(2050 + off), 32'(drive.wq.size()));
    p = 16'h0000;
    q = 16'h0000;
    for (int i = 0; i < 2048; i++) begin
      p ^= pat(i);
      if (^pat(i)) q ^= 16'(i);
      chk_val("drv_data", 32'(pat(i)),
        32'(drive.wq[i + ((pad && i >= 40) ? 9 : 0)]));
    end
    for (int i = 0; i < off; i++)
      chk_val("pad", 32'(pat(39)), 32'(drive.wq[40+i]));
    chk_val("ecc", {p, q},
      {drive.wq[2048+off], drive.wq[2049+off]});
  endtask

  task automatic read_sector(input logic flip);
    clr();
    rchk = !flip;
    flip_idx = flip ? 12'h064 : 12'hFFF;
    flip_mask = 16'h0020;
    start(1'b1);
    play = 1'b1;
    wait_done();
    play = 1'b0;
    chk_val("rd_count", 32'h800, 32'(rcnt));
    chk_bit("data_error", flip, s_de);
    chk_bit("swallow", 1'b1, sw_cnt >= 9);
    if (flip) begin
      chk_val("corr_mask", 32'h20, 32'(stat.corr_mask));
      chk_val("corr_index", 32'h5B, 32'(stat.corr_index));
    end
  endtask

  initial begin
    {rst_n, id_valid, up_valid, play, rchk} = 5'h00;
    ce = 1'b1;
    ctl = '0;
    id_word = 64'h0;
    id_code = 32'h0;
    up_data = 16'h0000;
    flip_idx = 12'hFFF;
    flip_mask = 16'h0000;
    err_total = 0;
    num_checks = 0;
    clr();
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    load_id(mk_id(12'hA33, 4'h0, 10'h204), 1'b0);
    chk_bit("addr_bad", 1'b1, stat.addr_bad);
    load_id(mk_id(12'hA32, 4'h0, 10'h204), 1'b0);
    chk_bit("addr_bad", 1'b0, stat.addr_bad);
    chk_bit("id_error", 1'b0, s_ide);
    load_id(mk_id(12'hA32, 4'h0, 10'h204), 1'b1);
    chk_bit("id_error", 1'b1, s_ide);
    // Write lock, read lock, then unmaskable flaw, all without override
    for (int t = 0; t < 3; t++) begin
      load_id(mk_id(12'h005, 4'(8 >> (t + t / 2)), 10'h204), 1'b0);
      start(t == 1);
      chk_bit("refused", 1'b1, s_ref);
      chk_bit("busy", 1'b0, busy);
    end
    load_id(mk_id(12'h010, 4'h2, 10'h00A), 1'b0);
    write_sector(1'b1);
    read_sector(1'b0);
    read_sector(1'b1);
    ctl.wr_lock_override = 1'b1;
    load_id(mk_id(12'h020, 4'hA, disk_fmt_pkg::DEFECT_NONE), 1'b0);
    write_sector(1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
